// file: rsc_defines.svh
// Constants for the serial real-time clock command block.
// Assumes inclusion by the package and the top module only.
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
// -------------------------------------------------------------
// Command byte fields
// -------------------------------------------------------------
`define RSC_CMD_DIR_BIT 7
`define RSC_CMD_SPACE_BIT 6
`define RSC_CMD_IDX_HI 5
`define RSC_CMD_IDX_LO 1
`define RSC_CMD_ENA_BIT 0
`define RSC_BURST_IDX 5'h1F
// -------------------------------------------------------------
// Clock register indices (command bits 5..1)
// -------------------------------------------------------------
`define RSC_IDX_SEC 5'h00
`define RSC_IDX_MIN 5'h01
`define RSC_IDX_HOUR 5'h02
`define RSC_IDX_DATE 5'h03
`define RSC_IDX_MONTH 5'h04
`define RSC_IDX_WDAY 5'h05
`define RSC_IDX_YEAR 5'h06
`define RSC_IDX_CTRL 5'h07
`define RSC_IDX_CENT 5'h09
`define RSC_NUM_TIME 7
`define RSC_BURST_LEN 4'h8
`define RSC_RAM_LEN 6'h1F
// -------------------------------------------------------------
// Field positions and reset values
// -------------------------------------------------------------
`define RSC_HOUR_FMT_BIT 7
`define RSC_HOUR_B5_BIT 5
`define RSC_CTRL_WP_BIT 7
`define RSC_CENT_RST 8'h19
`define RSC_SEC_RST 8'h00
`define RSC_HOUR_RST 8'h00
`define RSC_DATE_RST 8'h01
`define RSC_WDAY_RST 8'h01
`define RSC_LIVE_MASK0 8'h7F
`define RSC_DEFAULT_TICK_DIV 250000000
`endif

// file: rsc_pkg.sv
// Types shared by the serial real-time clock command block.
// Assumes rsc_defines.svh is on the include path.
`include "rsc_defines.svh"
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_ST_CMD = 2'b00,
    RSC_ST_DATA = 2'b01,
    RSC_ST_IDLE = 2'b10
  } rsc_state_t;

  typedef struct packed {
    logic rd;
    logic ram;
    logic [4:0] idx;
    logic ena;
  } rsc_cmd_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] wday;
    logic [7:0] year;
  } rsc_time_t;
endpackage

// file: rsc_rtc_serial.sv
// Serial command decoder, clock-setting buffer and scratch RAM of an RTC.
// Assumes SPI mode 0/3 on the link: data sampled on rising sclk, driven on falling.
`timescale 1ns/1ps
module rsc_rtc_serial
  import rsc_pkg::*;
#(
  parameter int unsigned TICK_DIV = `RSC_DEFAULT_TICK_DIV,
  parameter int unsigned RAM_DEPTH = 31
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_sec_tick,
  output logic [7:0] o_hours_count,
  output logic o_write_protect
);
  initial begin
    if (RAM_DEPTH != 31) $error("rsc_rtc_serial: RAM_DEPTH must be 31");
    if (TICK_DIV < 2) $error("rsc_rtc_serial: TICK_DIV must be at least 2");
  end

  // -------------------------------------------------------------
  // Link domain: shift register, bit counter, command decode
  // -------------------------------------------------------------
  // The link clock stops between frames; cs_n acts as its async reset so
  // a partial byte never survives into the next frame.
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  rsc_state_t lstate_q;
  rsc_cmd_t cmd_q;
  logic [5:0] byte_idx_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic wr_tgl_q;
  logic [7:0] wr_data_q;
  logic [5:0] wr_idx_q;
  logic rd_req_tgl_q;

  assign rx_byte = {shift_q, i_mosi};
  assign byte_done = (bit_cnt_q == 3'h7);

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= rx_byte[6:0];
    end
  end

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      lstate_q <= RSC_ST_CMD;
      cmd_q <= '0;
      byte_idx_q <= 6'h00;
    end else if (byte_done) begin
      unique case (lstate_q)
        RSC_ST_CMD: begin
          cmd_q <= rx_byte;
          byte_idx_q <= 6'h00;
          lstate_q <= RSC_ST_DATA;
        end
        RSC_ST_DATA: begin
          byte_idx_q <= byte_idx_q + 6'h01;
          if (cmd_q.idx == `RSC_BURST_IDX && cmd_q.ram && byte_idx_q == `RSC_RAM_LEN - 6'h01) begin
            lstate_q <= RSC_ST_IDLE;
          end
          if (cmd_q.idx == `RSC_BURST_IDX && !cmd_q.ram && byte_idx_q == 6'(`RSC_BURST_LEN) - 6'h01) begin
            lstate_q <= RSC_ST_IDLE;
          end
        end
        RSC_ST_IDLE: lstate_q <= RSC_ST_IDLE;
      endcase
    end
  end

  // Each complete write byte of an enabled command, until a burst ends, is handed to the system domain by a toggle.
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      wr_tgl_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_idx_q <= 6'h00;
      rd_req_tgl_q <= 1'b0;
    end else if (!i_cs_n && byte_done) begin
      if (lstate_q == RSC_ST_CMD && rx_byte[`RSC_CMD_DIR_BIT]) begin
        rd_req_tgl_q <= ~rd_req_tgl_q;
      end
      if (lstate_q == RSC_ST_DATA && !cmd_q.rd && cmd_q.ena) begin
        wr_tgl_q <= ~wr_tgl_q;
        wr_data_q <= rx_byte;
        wr_idx_q <= byte_idx_q;
      end
    end
  end

  // -------------------------------------------------------------
  // Read path: snapshot and outgoing shift on falling sclk
  // -------------------------------------------------------------
  // Snapshot words are held stable across the frame by the system side,
  // so reading them on the link clock is a quasi-static crossing.
  rsc_time_t snap_q;
  logic [7:0] ram_q [RAM_DEPTH];
  logic [7:0] cent_q;
  logic wp_q;
  logic [7:0] tx_byte;
  logic [5:0] rd_pos;
  logic [7:0] tx_q;

  assign rd_pos = (cmd_q.idx == `RSC_BURST_IDX) ? byte_idx_q : {1'b0, cmd_q.idx};

  always_comb begin
    tx_byte = 8'h00;
    if (cmd_q.ram) begin
      if (rd_pos < `RSC_RAM_LEN) tx_byte = ram_q[rd_pos[4:0]];
    end else begin
      unique case (rd_pos[4:0])
        `RSC_IDX_SEC: tx_byte = snap_q.sec;
        `RSC_IDX_MIN: tx_byte = snap_q.min;
        `RSC_IDX_HOUR: tx_byte = snap_q.hour;
        `RSC_IDX_DATE: tx_byte = snap_q.date;
        `RSC_IDX_MONTH: tx_byte = snap_q.month;
        `RSC_IDX_WDAY: tx_byte = snap_q.wday;
        `RSC_IDX_YEAR: tx_byte = snap_q.year;
        `RSC_IDX_CTRL: tx_byte = {wp_q, 7'h00};
        `RSC_IDX_CENT: tx_byte = (cmd_q.idx == `RSC_BURST_IDX) ? 8'h00 : cent_q;
        default: tx_byte = 8'h00;
      endcase
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      tx_q <= 8'h00;
    end else if (bit_cnt_q == 3'h0 && lstate_q == RSC_ST_DATA && cmd_q.rd) begin
      tx_q <= tx_byte;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign o_miso = tx_q[7];
  assign o_miso_oe = !i_cs_n && cmd_q.rd && lstate_q == RSC_ST_DATA;

  // -------------------------------------------------------------
  // System domain: synchronisers
  // -------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic wr_tgl_seen_q;
  logic rd_tgl_seen_q;
  logic cs_prev_q;
  logic wr_evt;
  logic rd_evt;
  logic cs_rise;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 3'b100;
      s2_q <= 3'b100;
      wr_tgl_seen_q <= 1'b0;
      rd_tgl_seen_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      s1_q <= {i_cs_n, rd_req_tgl_q, wr_tgl_q};
      s2_q <= s1_q;
      wr_tgl_seen_q <= s2_q[0];
      rd_tgl_seen_q <= s2_q[1];
      cs_prev_q <= s2_q[2];
    end
  end

  assign wr_evt = s2_q[0] ^ wr_tgl_seen_q;
  assign rd_evt = s2_q[1] ^ rd_tgl_seen_q;
  assign cs_rise = s2_q[2] && !cs_prev_q;

  // -------------------------------------------------------------
  // Seconds timebase
  // -------------------------------------------------------------
  logic [31:0] div_q;
  logic tick;
  assign tick = (div_q == TICK_DIV - 1);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) div_q <= 32'h0;
    else if (tick) div_q <= 32'h0;
    else div_q <= div_q + 32'h1;
  end

  // -------------------------------------------------------------
  // Holding buffer for time writes
  // -------------------------------------------------------------
  rsc_time_t buf_q;
  logic [6:0] buf_vld_q;
  logic buf_armed_q;
  logic commit_pend_q;
  logic [3:0] burst_cnt_q;
  logic burst_mode_q;
  logic wr_burst;
  logic wr_clock;
  logic wr_time_ok;
  logic wr_single;
  logic commit_ok;
  logic [4:0] wr_slot;

  assign wr_burst = cmd_q.idx == `RSC_BURST_IDX;
  assign wr_clock = wr_evt && !cmd_q.ram;
  assign wr_time_ok = wr_clock && !wp_q;
  assign wr_slot = wr_burst ? wr_idx_q[4:0] : cmd_q.idx;
  assign wr_single = wr_time_ok && !wr_burst && cmd_q.idx < 5'(`RSC_NUM_TIME);
  // The link side clears its command as soon as chip select rises, long
  // before the system side sees the rise, so the frame kind is kept here.
  assign commit_ok = burst_mode_q ? (burst_cnt_q == `RSC_BURST_LEN) : buf_armed_q;

  // Burst byte count and frame kind, both dropped at the end of every frame
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      burst_cnt_q <= 4'h0;
      burst_mode_q <= 1'b0;
    end else if (cs_rise) begin
      burst_cnt_q <= 4'h0;
      burst_mode_q <= 1'b0;
    end else if (wr_time_ok && wr_burst) begin
      burst_cnt_q <= burst_cnt_q + 4'h1;
      burst_mode_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buf_q <= '0;
    end else if (wr_time_ok) begin
      unique case (wr_slot)
        `RSC_IDX_SEC: buf_q.sec <= wr_data_q;
        `RSC_IDX_MIN: buf_q.min <= wr_data_q;
        `RSC_IDX_HOUR: buf_q.hour <= wr_data_q;
        `RSC_IDX_DATE: buf_q.date <= wr_data_q;
        `RSC_IDX_MONTH: buf_q.month <= wr_data_q;
        `RSC_IDX_WDAY: buf_q.wday <= wr_data_q;
        `RSC_IDX_YEAR: buf_q.year <= wr_data_q;
        default: buf_q.sec <= buf_q.sec;
      endcase
    end
  end

  // Single writes arm the buffer; only the fields they touched get loaded
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buf_armed_q <= 1'b0;
    end else if (cs_rise) begin
      buf_armed_q <= 1'b0;
    end else if (wr_single) begin
      buf_armed_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buf_vld_q <= 7'h00;
    end else if (cs_rise) begin
      if (!commit_ok) buf_vld_q <= 7'h00;
      else if (burst_mode_q) buf_vld_q <= '1;
    end else if (commit_pend_q && !tick) begin
      buf_vld_q <= 7'h00;
    end else if (wr_single) begin
      buf_vld_q[cmd_q.idx[2:0]] <= 1'b1;
    end
  end

  // A commit that meets a seconds increment waits one clock instead
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      commit_pend_q <= 1'b0;
    end else if (cs_rise) begin
      commit_pend_q <= commit_ok;
    end else if (commit_pend_q && !tick) begin
      commit_pend_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Live counters, control, century and RAM
  // -------------------------------------------------------------
  // Only seconds advances here; the calendar carry chain lives elsewhere.
  rsc_time_t live_q;
  logic do_commit;
  assign do_commit = commit_pend_q && !tick && !cs_rise;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      live_q <= '{`RSC_SEC_RST, 8'h00, `RSC_HOUR_RST, `RSC_DATE_RST, 8'h01, `RSC_WDAY_RST, 8'h00};
    end else if (do_commit) begin
      if (buf_vld_q[0]) live_q.sec <= buf_q.sec;
      if (buf_vld_q[1]) live_q.min <= buf_q.min;
      if (buf_vld_q[2]) live_q.hour <= buf_q.hour;
      if (buf_vld_q[3]) live_q.date <= buf_q.date;
      if (buf_vld_q[4]) live_q.month <= buf_q.month;
      if (buf_vld_q[5]) live_q.wday <= buf_q.wday;
      if (buf_vld_q[6]) live_q.year <= buf_q.year;
    end else if (tick) begin
      live_q.sec <= (live_q.sec[3:0] == 4'h9) ?
        ((live_q.sec[6:4] == 3'h5) ? 8'h00 : {1'b0, live_q.sec[6:4] + 3'h1, 4'h0}) :
        (live_q.sec + 8'h01) & `RSC_LIVE_MASK0;
    end
  end

  // Snapshot is refreshed on a read command, but never on a tick cycle.
  logic snap_pend_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      snap_q <= '0;
      snap_pend_q <= 1'b0;
    end else if ((rd_evt || snap_pend_q) && !tick) begin
      snap_q <= live_q;
      snap_pend_q <= 1'b0;
    end else if (rd_evt) begin
      snap_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= 1'b0;
      cent_q <= `RSC_CENT_RST;
    end else if (wr_clock) begin
      if ((wr_burst ? wr_idx_q[4:0] : cmd_q.idx) == `RSC_IDX_CTRL) begin
        wp_q <= wr_data_q[`RSC_CTRL_WP_BIT];
      end
      if (!wr_burst && cmd_q.idx == `RSC_IDX_CENT && !wp_q) cent_q <= wr_data_q;
    end
  end

  logic [5:0] ram_addr;
  assign ram_addr = wr_burst ? wr_idx_q : {1'b0, cmd_q.idx};

  generate
    for (genvar g = 0; g < RAM_DEPTH; g++) begin : g_ram
      always_ff @(posedge i_clk_sys) begin
        if (wr_evt && cmd_q.ram && !wp_q && ram_addr == 6'(g)) ram_q[g] <= wr_data_q;
      end
    end
  endgenerate

  assign o_sec_tick = tick;
  assign o_hours_count = live_q.hour;
  assign o_write_protect = wp_q;
endmodule

// file: rsc_rtc_serial_chk.sv
// Checker for the serial RTC command block, bound to its top module.
// Assumes only the top module's ports; SPI mode 3 link.
`timescale 1ns/1ps
module rsc_rtc_serial_chk #(
  parameter int unsigned TICK_DIV = 50
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  input wire logic o_sec_tick,
  input wire logic [7:0] o_hours_count,
  input wire logic o_write_protect
);
  logic [31:0] gap_q;
  logic seen_q;
  logic [7:0] hi_q;
  logic [3:0] bits_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= o_sec_tick ? 32'h0 : gap_q + 32'h1;
      seen_q <= seen_q | o_sec_tick;
    end
  end
  // Cycles since chip select went high; commits must land shortly after
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) hi_q <= 8'h00;
    else hi_q <= !i_cs_n ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
  end
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) bits_q <= 4'h0;
    else bits_q <= (bits_q == 4'hF) ? bits_q : bits_q + 4'h1;
  end
  a_tick_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_sec_tick |=> !o_sec_tick) else $error("tick longer than one cycle");
  a_tick_period: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_sec_tick && seen_q |-> gap_q == TICK_DIV - 1) else $error("tick period wrong");
  a_oe_cmd: assert property (@(posedge i_sclk) disable iff (i_rst)
    bits_q < 4'h8 |-> !o_miso_oe) else $error("miso driven during command byte");
  a_oe_cs: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_miso_oe |-> !i_cs_n) else $error("miso driven with cs high");
  a_hours_commit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_hours_count) |-> i_cs_n && hi_q inside {[1:12]}) else $error("hours moved outside commit");
  a_hours_notick: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_hours_count) |-> !$past(o_sec_tick)) else $error("commit on tick cycle");
  a_hours_wp: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_hours_count) |-> !$past(o_write_protect, 2)) else $error("hours written while protected");
  a_wp_link: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_write_protect) |-> hi_q <= 8'h0C) else $error("protect moved without a frame");
endmodule
bind rsc_rtc_serial rsc_rtc_serial_chk #(.TICK_DIV(TICK_DIV)) u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
  .o_sec_tick(o_sec_tick), .o_hours_count(o_hours_count), .o_write_protect(o_write_protect));

// file: rsc_spi_master.sv
// SPI mode 3 master model driving the RTC link.
// Assumes the caller spaces frames; sclk idles high between frames.
`timescale 1ns/1ps
module rsc_spi_master (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // Odd offset keeps link edges off the system clock edges
  task automatic open_f();
    #41.3;
    o_cs_n = 1'b0;
    #40;
  endtask
  task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_sclk = 1'b0;
      o_mosi = tx[i];
      #40;
      // Sampled just ahead of the rising edge so enable changes there cannot race
      rx[i] = i_miso;
      o_sclk = 1'b1;
      #40;
    end
  endtask
  // Released data line toggles so a stale bit is never mistaken for data
  task automatic close_f();
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #200;
  endtask
endmodule

// file: rsc_rtc_serial_tb_top.sv
// Self-checking testbench for the serial RTC command block.
// Assumes the master model and the checker are compiled before it.
`timescale 1ns/1ps
module rsc_rtc_serial_tb_top;
  import rsc_pkg::*;
  // Short second so several ticks fall inside the run
  localparam int unsigned TDIV = 4000;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  wire sclk, cs_n, mosi;
  logic miso, oe, tick, wp;
  wire miso_line;
  logic [7:0] hrs, d;
  logic [7:0] tv [8] = '{8'h31, 8'h11, 8'hB0, 8'h04, 8'h07, 8'h05, 8'h02, 8'h00};
  int mismatches = 0;
  int n_checks = 0;
  always #2 i_clk_sys = ~i_clk_sys;
  rsc_rtc_serial #(.TICK_DIV(TDIV)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .o_sec_tick(tick), .o_hours_count(hrs), .o_write_protect(wp));
  // A released data line shows the inverse, so reads outside the enable window fail
  assign miso_line = oe ? miso : ~miso;
  rsc_spi_master u_mst (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_line));
  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic x(input logic [7:0] t);
    u_mst.xbits(t, 8, d);
  endtask
  task automatic wr1(input logic [7:0] cmd, input logic [7:0] dat, input int n);
    u_mst.open_f();
    x(cmd);
    u_mst.xbits(dat, n, d);
    u_mst.close_f();
  endtask
  task automatic rd1(input logic [7:0] cmd);
    u_mst.open_f();
    x(cmd);
    x(8'hFF);
    u_mst.close_f();
  endtask
  task automatic t_reset();
    chk(hrs, 8'h00, "hours reset");
    chk({7'h00, wp}, 8'h00, "protect reset");
    rd1(8'h93);
    chk(d, 8'h19, "century reset");
  endtask
  task automatic t_burst();
    u_mst.open_f();
    x(8'h3F);
    for (int i = 0; i < 8; i++) x(tv[i]);
    repeat (20) @(negedge i_clk_sys);
    chk(hrs, 8'h00, "hours before cs rise");
    u_mst.close_f();
    chk(hrs, 8'hB0, "hours after burst");
    u_mst.open_f();
    x(8'hBF);
    for (int i = 0; i < 8; i++) begin
      x(8'hFF);
      // One tick may fall between the write and the read
      if (i == 0 && d === 8'h32) d = 8'h31;
      chk(d, tv[i], "burst read");
    end
    u_mst.close_f();
  endtask
  task automatic t_short();
    logic [7:0] s0;
    s0 = 8'h00;
    u_mst.open_f();
    x(8'h3F);
    for (int i = 0; i < 7; i++) x(8'h12);
    u_mst.close_f();
    chk(hrs, 8'hB0, "short burst");
    wr1(8'h05, 8'h12, 5);
    chk(hrs, 8'hB0, "partial byte");
    // Seconds reads bracket the single write; a tick in between forces a retry
    for (int k = 0; k < 3; k++) begin
      rd1(8'h81);
      s0 = d;
      wr1(8'h05, 8'h23, 8);
      rd1(8'h81);
      if (d === s0) break;
    end
    chk(d, s0, "seconds bracket");
    chk(hrs, 8'h23, "single write");
    wr1(8'h04, 8'h15, 8);
    chk(hrs, 8'h23, "enable bit low");
    rd1(8'h85);
    chk(d, 8'h23, "single read");
  endtask
  task automatic t_ram();
    u_mst.open_f();
    x(8'h7F);
    for (int i = 0; i < 31; i++) x(8'hA0 + 8'(i));
    u_mst.close_f();
    u_mst.open_f();
    x(8'h7F);
    x(8'h55);
    x(8'h66);
    u_mst.close_f();
    u_mst.open_f();
    x(8'hFF);
    for (int i = 0; i < 31; i++) begin
      x(8'hFF);
      chk(d, i == 0 ? 8'h55 : i == 1 ? 8'h66 : 8'hA0 + 8'(i), "ram burst");
    end
    u_mst.close_f();
    rd1(8'hC3);
    chk(d, 8'h66, "ram single read");
  endtask
  task automatic t_protect();
    wr1(8'h0F, 8'hFF, 8);
    chk({7'h00, wp}, 8'h01, "protect set");
    rd1(8'h8F);
    chk(d, 8'h80, "control read");
    wr1(8'h05, 8'h11, 8);
    chk(hrs, 8'h23, "hours protected");
    wr1(8'h41, 8'hAA, 8);
    rd1(8'hC1);
    chk(d, 8'h55, "ram protected");
    wr1(8'h0F, 8'h00, 8);
    chk({7'h00, wp}, 8'h00, "protect cleared");
  endtask
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    t_reset();
    t_burst();
    t_short();
    t_ram();
    t_protect();
    stop_test();
  end
  // Whole run is near 85 us; this limit only trips on a hang
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
